/* inc/timer_consts.svh */
// register map, field positions, reset values and the operation summary of the timer block
// Operation
// - timers step at most once per two system clock cycles
// - core timer, auxiliary timer and capture_reload_reg are separate elements
// - auxiliary timer counts prescaled system clock ticks or external signals, as configured; core timer counts prescaled ticks only
// - count direction set by software or by the direction_input_pin level
// - core_toggle_latch inverts on every core timer overflow or underflow
// - toggle latch can clock the auxiliary timer and drive toggle_output_pin
// - core timer wraps are offered as clock to capture_compare_unit_timers
// - core timer wraps can reload the core timer from capture_reload_reg
// - capture_reload_reg latches auxiliary count on selected capture_input_pin transition
// - optional clear of auxiliary timer right after each capture, else undisturbed
// - capture may instead follow first_module_count_input and/or direction input transitions
// - both timers are sixteen bits wide
// - core timer has no external count or direction input
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

`define TMR_W 16
`define OFS_CORE_CTL 8'h00
`define OFS_AUX_CTL 8'h04
`define OFS_CORE_CNT 8'h08
`define OFS_AUX_CNT 8'h0c
`define OFS_CAP_RELOAD 8'h10
`define OFS_STATUS 8'h14
`define OFS_MASK 8'h18

// core control fields
`define CC_RUN 0
`define CC_DOWN 1
`define CC_PRE_LO 2
`define CC_PRE_HI 4
`define CC_RELOAD 5
`define CC_OUT_EN 6
`define CC_LATCH 7
// auxiliary control fields
`define AC_RUN 0
`define AC_DOWN 1
`define AC_EXT_DIR 2
`define AC_PRE_LO 3
`define AC_PRE_HI 5
`define AC_SRC_LO 6
`define AC_SRC_HI 7
`define AC_EDGE_LO 8
`define AC_EDGE_HI 9
`define AC_CAP_FM 10
`define AC_FM_LO 11
`define AC_FM_HI 12
`define AC_CLR 13
// status and mask bits
`define ST_CORE 0
`define ST_AUX 1
`define ST_CAP 2

`define RST_CTL 16'h0000
`define RST_CNT 16'h0000
`define RST_ST 3'h0
`endif

/* inc/timer_pkg.sv */
// types shared by the timer block
package timer_pkg;
    typedef enum logic [1:0] {
        SRC_PRESC = 2'b00,
        SRC_PIN = 2'b01,
        SRC_LATCH = 2'b10,
        SRC_NONE = 2'b11
    } aux_src_t;
    typedef logic [15:0] count_t;
endpackage

/* inc/timer_if.sv */
// control and result signals between the block and one timer unit
`timescale 1ns/100ps
interface timer_if;
    logic step;
    logic up;
    logic clear;
    logic sw_load;
    timer_pkg::count_t sw_val;
    logic reload_en;
    timer_pkg::count_t reload_val;
    timer_pkg::count_t count;
    logic wrap;
    modport ctrl (output step, up, clear, sw_load, sw_val, reload_en, reload_val,
        input count, wrap);
    modport unit (input step, up, clear, sw_load, sw_val, reload_en, reload_val,
        output count, wrap);
endinterface

/* verilog/timer_unit.sv */
// one sixteen bit up/down timer with load, clear and reload on wrap
`timescale 1ns/100ps
`include "timer_consts.svh"
module timer_unit (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control from the block
    timer_if.unit t
);
    localparam timer_pkg::count_t ONES = 16'hffff;

    // software load wins over clear, clear over counting
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            t.count <= `RST_CNT;
            t.wrap <= 1'b0;
        end else begin
            t.wrap <= 1'b0;
            if (t.sw_load) begin
                t.count <= t.sw_val;
            end else if (t.clear) begin
                t.count <= `RST_CNT;
            end else if (t.step) begin
                if (t.up && t.count == ONES) begin
                    t.wrap <= 1'b1;
                    t.count <= t.reload_en ? t.reload_val : 16'h0000;
                end else if (!t.up && t.count == 16'h0000) begin
                    t.wrap <= 1'b1;
                    t.count <= t.reload_en ? t.reload_val : ONES;
                end else begin
                    t.count <= t.up ? t.count + 16'h0001 : t.count - 16'h0001;
                end
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_plain_step;
        t.step && !t.sw_load && !t.clear && !t.reload_en;
    endsequence

    property p_wrap_up;
        s_plain_step and (t.up && t.count == ONES) |=> t.count == 16'h0000 && t.wrap;
    endproperty
    a_wrap_up: assert property (p_wrap_up) else $error("up wrap wrong");

    property p_wrap_dn;
        s_plain_step and (!t.up && t.count == 16'h0000) |=> t.count == ONES && t.wrap;
    endproperty
    a_wrap_dn: assert property (p_wrap_dn) else $error("down wrap wrong");

    property p_reload;
        t.step && t.reload_en && !t.sw_load && !t.clear &&
            ((t.up && t.count == ONES) || (!t.up && t.count == 16'h0000))
            |=> t.count == $past(t.reload_val) && t.wrap;
    endproperty
    a_reload: assert property (p_reload) else $error("reload missed");

    property p_hold;
        !t.step && !t.sw_load && !t.clear |=> $stable(t.count) && !t.wrap;
    endproperty
    a_hold: assert property (p_hold) else $error("count moved without step");
endmodule

/* verilog/second_timer_module.sv */
// second timer module: core and auxiliary timers, toggle latch, capture/reload, wishbone slave
//
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/100ps
`include "timer_consts.svh"
module second_timer_module (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // pins
    input wire logic aux_count_pin_i,
    input wire logic direction_input_pin_i,
    input wire logic capture_input_pin_i,
    input wire logic first_module_count_input_i,
    input wire logic first_module_direction_input_i,
    output logic toggle_output_pin_o,
    // events to neighbours and interrupt
    output logic capcom_clk_o,
    output logic irq_o
);
    // pin index in the synchroniser
    localparam int P_CNT = 0;
    localparam int P_DIR = 1;
    localparam int P_CAP = 2;
    localparam int P_FMC = 3;
    localparam int P_FMD = 4;

    timer_if core_t ();
    timer_if aux_t ();

    logic [15:0] core_ctl;
    logic [15:0] aux_ctl;
    logic [15:0] capreg;
    logic [2:0] status;
    logic [2:0] mask;
    logic core_latch;
    logic [7:0] presc;
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic [4:0] sync_c;
    logic [4:0] rise;
    logic [4:0] fall;
    logic req;
    logic wr_go;
    logic rd_go;
    logic [7:0] ofs;
    logic cap_evt;
    logic pin_evt;
    logic fm_evt;
    logic [2:0] next_status;
    logic [31:0] rd_val;
    timer_pkg::aux_src_t aux_src;

    // byte lanes 0 and 1 carry the sixteen bit registers
    function automatic logic [15:0] lanes(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
        lanes = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    // prescaler tick with period 2^(p+1), never faster than every second cycle
    function automatic logic presc_tick(input logic [7:0] c, input logic [2:0] p);
        logic [7:0] m;
        m = 8'((9'h002 << p) - 9'h001);
        presc_tick = (c & m) == m;
    endfunction

    timer_unit core_unit (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .t(core_t.unit)
    );

    timer_unit aux_unit (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .t(aux_t.unit)
    );

    // two flops before any logic, third flop only for edge detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_a <= 5'h00;
            sync_b <= 5'h00;
            sync_c <= 5'h00;
        end else begin
            sync_a <= {first_module_direction_input_i, first_module_count_input_i,
                       capture_input_pin_i, direction_input_pin_i, aux_count_pin_i};
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    assign rise = sync_b & ~sync_c;
    assign fall = ~sync_b & sync_c;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            presc <= 8'h00;
        end else begin
            presc <= presc + 8'h01;
        end
    end

    // core timer: prescaled clock only, it has no external count or direction
    assign core_t.step = core_ctl[`CC_RUN] &&
        presc_tick(presc, core_ctl[`CC_PRE_HI:`CC_PRE_LO]);
    assign core_t.up = !core_ctl[`CC_DOWN];
    assign core_t.clear = 1'b0;
    assign core_t.sw_load = wr_go && ofs == `OFS_CORE_CNT;
    assign core_t.sw_val = lanes(core_t.count, wb_dat_i, wb_sel_i);
    assign core_t.reload_en = core_ctl[`CC_RELOAD];
    assign core_t.reload_val = capreg;

    // auxiliary timer clock source
    assign aux_src = timer_pkg::aux_src_t'(aux_ctl[`AC_SRC_HI:`AC_SRC_LO]);

    always_comb begin
        aux_t.step = 1'b0;
        case (aux_src)
            timer_pkg::SRC_PRESC: aux_t.step =
                presc_tick(presc, aux_ctl[`AC_PRE_HI:`AC_PRE_LO]);
            timer_pkg::SRC_PIN: aux_t.step = rise[P_CNT];
            // each latch transition coincides with a core wrap pulse
            timer_pkg::SRC_LATCH: aux_t.step = core_t.wrap;
            default: aux_t.step = 1'b0;
        endcase
        aux_t.step = aux_t.step && aux_ctl[`AC_RUN];
    end

    assign aux_t.up = aux_ctl[`AC_EXT_DIR] ? !sync_b[P_DIR] : !aux_ctl[`AC_DOWN];
    assign aux_t.sw_load = wr_go && ofs == `OFS_AUX_CNT;
    assign aux_t.sw_val = lanes(aux_t.count, wb_dat_i, wb_sel_i);
    assign aux_t.reload_en = 1'b0;
    assign aux_t.reload_val = 16'h0000;
    assign aux_t.clear = cap_evt && aux_ctl[`AC_CLR];

    // capture trigger selection
    assign pin_evt = (aux_ctl[`AC_EDGE_LO] && rise[P_CAP]) ||
                     (aux_ctl[`AC_EDGE_HI] && fall[P_CAP]);
    assign fm_evt = (aux_ctl[`AC_FM_LO] && (rise[P_FMC] || fall[P_FMC])) ||
                    (aux_ctl[`AC_FM_HI] && (rise[P_FMD] || fall[P_FMD]));
    assign cap_evt = aux_ctl[`AC_CAP_FM] ? fm_evt : pin_evt;

    // a capture beats a software write in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            capreg <= `RST_CNT;
        end else if (cap_evt) begin
            capreg <= aux_t.count;
        end else if (wr_go && ofs == `OFS_CAP_RELOAD) begin
            capreg <= lanes(capreg, wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_latch <= 1'b0;
            toggle_output_pin_o <= 1'b0;
            capcom_clk_o <= 1'b0;
        end else begin
            if (core_t.wrap) begin
                core_latch <= !core_latch;
            end
            toggle_output_pin_o <= core_latch && core_ctl[`CC_OUT_EN];
            capcom_clk_o <= core_t.wrap;
        end
    end

    // wishbone: ack one cycle after the request, dropped the cycle after
    assign req = wb_cyc_i && wb_stb_i;
    assign wr_go = req && wb_we_i && !wb_ack_o;
    assign rd_go = req && !wb_we_i && !wb_ack_o;
    assign ofs = {wb_adr_i[7:2], 2'b00};

    always_comb begin
        rd_val = 32'h0000_0000;
        case (ofs)
            `OFS_CORE_CTL: rd_val = {16'h0000, core_ctl[15:8], core_latch, core_ctl[6:0]};
            `OFS_AUX_CTL: rd_val = {16'h0000, aux_ctl};
            `OFS_CORE_CNT: rd_val = {16'h0000, core_t.count};
            `OFS_AUX_CNT: rd_val = {16'h0000, aux_t.count};
            `OFS_CAP_RELOAD: rd_val = {16'h0000, capreg};
            `OFS_STATUS: rd_val = {29'h0000_0000, status};
            `OFS_MASK: rd_val = {29'h0000_0000, mask};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req && !wb_ack_o;
            if (rd_go) begin
                wb_dat_o <= rd_val;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_ctl <= `RST_CTL;
            aux_ctl <= `RST_CTL;
            mask <= `RST_ST;
        end else if (wr_go) begin
            if (ofs == `OFS_CORE_CTL) begin
                core_ctl <= lanes(core_ctl, wb_dat_i, wb_sel_i);
            end
            if (ofs == `OFS_AUX_CTL) begin
                aux_ctl <= lanes(aux_ctl, wb_dat_i, wb_sel_i);
            end
            if (ofs == `OFS_MASK && wb_sel_i[0]) begin
                mask <= wb_dat_i[2:0];
            end
        end
    end

    // read clears; an event in the clearing cycle stays set
    always_comb begin
        next_status = status;
        if (rd_go && ofs == `OFS_STATUS) begin
            next_status = 3'h0;
        end
        next_status[`ST_CORE] = next_status[`ST_CORE] | core_t.wrap;
        next_status[`ST_AUX] = next_status[`ST_AUX] | aux_t.wrap;
        next_status[`ST_CAP] = next_status[`ST_CAP] | cap_evt;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= `RST_ST;
            irq_o <= 1'b0;
        end else begin
            status <= next_status;
            irq_o <= |(next_status & mask);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_step_gap;
        core_t.step |=> !core_t.step;
    endproperty
    a_step_gap: assert property (p_step_gap) else $error("core stepped twice");

    property p_toggle;
        core_t.wrap |=> core_latch != $past(core_latch);
    endproperty
    a_toggle: assert property (p_toggle) else $error("latch did not toggle");

    // the enable must still stand when the pin flop loads the new latch state
    property p_pin_out;
        core_t.wrap && core_ctl[`CC_OUT_EN] ##1 core_ctl[`CC_OUT_EN]
            |=> toggle_output_pin_o == !$past(core_latch, 2);
    endproperty
    a_pin_out: assert property (p_pin_out) else $error("toggle pin wrong");

    property p_capcom;
        core_t.wrap |=> capcom_clk_o ##1 !capcom_clk_o;
    endproperty
    a_capcom: assert property (p_capcom) else $error("capcom pulse wrong");

    property p_capture;
        cap_evt |=> capreg == $past(aux_t.count) && status[`ST_CAP];
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed");

    sequence s_cap_clear;
        cap_evt && aux_ctl[`AC_CLR] && !aux_t.sw_load;
    endsequence

    property p_clear;
        s_cap_clear |=> aux_t.count == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) else $error("aux not cleared");

    property p_keep;
        cap_evt && !aux_ctl[`AC_CLR] && !aux_t.sw_load && !aux_t.step |=> $stable(aux_t.count);
    endproperty
    a_keep: assert property (p_keep) else $error("aux disturbed");

    property p_fm;
        aux_ctl[`AC_CAP_FM] && aux_ctl[`AC_FM_LO] && rise[P_FMC] |=> status[`ST_CAP];
    endproperty
    a_fm: assert property (p_fm) else $error("first module capture missed");

    property p_ext_dir;
        aux_ctl[`AC_EXT_DIR] && sync_b[P_DIR] && aux_t.step && !aux_t.clear && !aux_t.sw_load &&
            aux_t.count != 16'h0000 |=> aux_t.count == $past(aux_t.count) - 16'h0001;
    endproperty
    a_ext_dir: assert property (p_ext_dir) else $error("direction pin ignored");

    property p_latch_hold;
        !core_t.wrap |=> $stable(core_latch);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch moved without wrap");

    property p_irq;
        1'b1 |=> irq_o == |(status & $past(mask));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");
endmodule

/* testbench/pin_partner.sv */
// far-side pin model: external count, direction, capture and first module inputs
`timescale 1ns/100ps
module pin_partner (
    // clock
    input wire logic clk_i,
    // pins toward the block
    output logic count_o,
    output logic dir_o,
    output logic cap_o,
    output logic fm_count_o,
    output logic fm_dir_o
);
    initial begin
        count_o = 1'b0;
        dir_o = 1'b0;
        cap_o = 1'b0;
        fm_count_o = 1'b0;
        fm_dir_o = 1'b0;
    end
    // levels held four clocks so the two-flop synchroniser never misses one
    task automatic hold4();
        repeat (4) @(posedge clk_i);
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk_i);
            count_o <= 1'b1;
            hold4();
            count_o <= 1'b0;
            hold4();
        end
    endtask
    // 0 direction, 1 capture, 2 first module count, 3 first module direction
    task automatic flip(input int which);
        @(posedge clk_i);
        case (which)
            0: dir_o <= ~dir_o;
            1: cap_o <= ~cap_o;
            2: fm_count_o <= ~fm_count_o;
            default: fm_dir_o <= ~fm_dir_o;
        endcase
        hold4();
    endtask
endmodule

/* testbench/second_timer_module_tb.sv */
// self-checking bench for the second timer module
`timescale 1ns/100ps
`include "timer_consts.svh"
module second_timer_module_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic cnt_pin, dir_pin, cap_pin, fm_cnt, fm_dir;
    logic toggle_output_pin_o, capcom_clk_o, irq_o;
    logic [31:0] rd;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    int wraps = 0;
    // capture trigger selections: rising, falling, both, first module count, direction
    localparam logic [15:0] cap_sel [5] = '{16'h0100, 16'h0200, 16'h0300, 16'h0c00, 16'h1400};

    always #20 clk_i = ~clk_i;

    second_timer_module second_timer_module_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .aux_count_pin_i(cnt_pin),
        .direction_input_pin_i(dir_pin), .capture_input_pin_i(cap_pin),
        .first_module_count_input_i(fm_cnt), .first_module_direction_input_i(fm_dir),
        .toggle_output_pin_o(toggle_output_pin_o), .capcom_clk_o(capcom_clk_o),
        .irq_o(irq_o));

    pin_partner partner_inst (.clk_i(clk_i), .count_o(cnt_pin), .dir_o(dir_pin),
        .cap_o(cap_pin), .fm_count_o(fm_cnt), .fm_dir_o(fm_dir));

    task automatic conclude();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic fail(input string msg);
        mismatches++;
        $display("ERROR %0t %s", $time, msg);
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) fail($sformatf("value %h expected %h", got, exp));
    endtask
    task automatic check_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) fail($sformatf("pin %b expected %b", got, exp));
    endtask
    // two steps per reload round, one step every 2^(p+1) clocks
    function automatic logic [31:0] wrap_period(input int p);
        return 32'(2 << (p + 1));
    endfunction
    // one classic cycle; no latency assumed, only the timeout ends a wait
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'h3;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        bus(1'b1, adr, dat);
    endtask
    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0);
        check_val(rd, exp);
    endtask
    task automatic wait_pulse(output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (capcom_clk_o !== 1'b1);
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (capcom_clk_o === 1'b1) wraps++;
        if (cycles == 20000) begin
            fail("timeout");
            conclude();
        end
    end

    initial begin
        int n, m, v, g;
        logic tg;
        void'($urandom(83430));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        // 0x1c is unmapped and must read zero as well
        for (int a = 0; a < 8; a++) rdchk(8'(a * 4), 32'h0);
        wr(`OFS_MASK, 32'h1);
        for (int p = 0; p < 3; p++) begin
            wr(`OFS_CAP_RELOAD, 32'hfffe);
            wr(`OFS_CORE_CNT, 32'hfffe);
            wr(`OFS_AUX_CNT, 32'h0);
            wr(`OFS_AUX_CTL, 32'h81);
            wraps = 0;
            wr(`OFS_CORE_CTL, 32'h61 | 32'(p << 2));
            wait_pulse(g);
            tg = toggle_output_pin_o;
            wait_pulse(g);
            check_val(32'(g), wrap_period(p));
            check_bit(toggle_output_pin_o, ~tg);
            wr(`OFS_CORE_CTL, 32'h0);
            repeat (10) @(posedge clk_i);
            rdchk(`OFS_AUX_CNT, 32'(wraps));
        end
        check_bit(irq_o, 1'b1);
        rdchk(`OFS_STATUS, 32'h1);
        repeat (3) @(posedge clk_i);
        check_bit(irq_o, 1'b0);
        // slowest prescaler leaves time to read the wrapped value
        for (int d = 0; d < 2; d++) begin
            wr(`OFS_CORE_CNT, d ? 32'h0 : 32'hffff);
            wr(`OFS_CORE_CTL, 32'h1d | 32'(d << 1));
            wait_pulse(g);
            rdchk(`OFS_CORE_CNT, d ? 32'hffff : 32'h0);
        end
        wr(`OFS_CORE_CTL, 32'h0);
        n = $urandom_range(8, 2);
        m = $urandom_range(n - 1, 1);
        wr(`OFS_AUX_CNT, 32'h0);
        wr(`OFS_AUX_CTL, 32'h41);
        partner_inst.pulse(n);
        rdchk(`OFS_AUX_CNT, 32'(n));
        wr(`OFS_AUX_CTL, 32'h45);
        partner_inst.flip(0);
        partner_inst.pulse(m);
        rdchk(`OFS_AUX_CNT, 32'(n - m));
        wr(`OFS_AUX_CTL, 32'h41);
        partner_inst.pulse(1);
        rdchk(`OFS_AUX_CNT, 32'(n - m + 1));
        for (int i = 0; i < 5; i++) begin
            v = $urandom_range(16'hffff, 1);
            wr(`OFS_MASK, (i % 2) ? 32'h0 : 32'h4);
            wr(`OFS_AUX_CTL, 32'(cap_sel[i]) | 32'hc1 | 32'((i % 2) << 13));
            wr(`OFS_AUX_CNT, 32'(v));
            bus(1'b0, `OFS_STATUS, 32'h0);
            partner_inst.flip(i < 3 ? 1 : i - 1);
            repeat (4) @(posedge clk_i);
            check_bit(irq_o, !(i % 2));
            rdchk(`OFS_CAP_RELOAD, 32'(v));
            rdchk(`OFS_AUX_CNT, (i % 2) ? 32'h0 : 32'(v));
            rdchk(`OFS_STATUS, 32'h4);
        end
        // auxiliary timer on the fastest prescaler, counting down by software from zero
        wr(`OFS_MASK, 32'h2);
        wr(`OFS_AUX_CNT, 32'h0);
        wr(`OFS_AUX_CTL, 32'h03);
        repeat (4) @(posedge clk_i);
        wr(`OFS_AUX_CTL, 32'h0);
        check_bit(irq_o, 1'b1);
        rdchk(`OFS_STATUS, 32'h2);
        conclude();
    end
endmodule
